/* File: design/disp_i2c_pkg.sv */
// constants, types and state layout for the display two-wire write port
package disp_i2c_pkg;

  // ----------------------------------------
  // address and layout
  // ----------------------------------------
  localparam logic [5:0] ADDR_UPPER = 6'h1E;
  localparam int CTRL_CONT_BIT = 7;
  localparam int CTRL_DC_BIT = 6;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [7:0] COL_LAST = 8'h9F;

  // ----------------------------------------
  // reset values
  // ----------------------------------------
  localparam logic [7:0] CONTRAST_RST = 8'h7F;
  localparam logic [7:0] COL_RST = 8'h00;
  localparam logic [7:0] START_LINE_RST = 8'h00;

  // ----------------------------------------
  // command opcodes
  // ----------------------------------------
  localparam logic [7:0] OP_DISP_OFF = 8'hAE;
  localparam logic [7:0] OP_DISP_ON = 8'hAF;
  localparam logic [7:0] OP_CONTRAST = 8'h81;
  localparam logic [7:0] OP_START_LINE = 8'hA2;
  localparam logic [7:0] OP_COL_SET = 8'h15;
  localparam logic [7:0] OP_PORTRAIT = 8'h25;
  localparam logic [7:0] OP_COL_NORMAL = 8'hA0;
  localparam logic [7:0] OP_COL_REMAP = 8'hA1;
  localparam logic [7:0] OP_COM_NORMAL = 8'hC0;
  localparam logic [7:0] OP_COM_REMAP = 8'hC8;
  localparam logic [5:0] OP_MODE_BASE = 6'h29;

  // ----------------------------------------
  // types
  // ----------------------------------------
  typedef enum logic [2:0] {ST_IDLE, ST_ADDR, ST_CTRL, ST_PAY, ST_IGNORE} link_state_e;

  typedef struct packed {
    logic display_on;
    logic portrait;
    logic col_remap;
    logic com_remap;
    logic [1:0] disp_mode;
    logic [7:0] start_line;
    logic [7:0] contrast;
  } display_cfg_s;

  localparam display_cfg_s CFG_RST = '{
    display_on: 1'b0, portrait: 1'b0, col_remap: 1'b0, com_remap: 1'b0,
    disp_mode: 2'h0, start_line: START_LINE_RST, contrast: CONTRAST_RST};

  typedef struct packed {
    logic scl_s1;
    logic scl_s2;
    logic scl_q;
    logic sda_s1;
    logic sda_s2;
    logic sda_q;
    logic sel_s1;
    logic sel_s2;
    logic rst_s1;
    logic rst_s2;
    link_state_e st;
    logic [2:0] bit_cnt;
    logic [7:0] shift;
    logic byte_done;
    logic ack_en;
    logic in_ack;
    logic cont;
    logic dc;
    logic [7:0] col;
    logic arg_pend;
    logic [7:0] arg_op;
    logic sda_oe;
    logic sda_out;
    logic ram_wr;
    logic [7:0] ram_data;
    logic [7:0] ram_col;
    logic cmd_wr;
    logic [7:0] cmd_byte;
    logic busy;
    display_cfg_s cfg;
  } port_state_s;

  function automatic logic addr_match(input logic [6:0] addr, input logic sel);
    addr_match = (addr[6:1] == ADDR_UPPER) && (addr[0] == sel);
  endfunction

endpackage

/* File: design/display_i2c_write_port.sv */
// two-wire write-only slave port with command/data split and reset-pin state
`timescale 1ns/1ps
`default_nettype none
module display_i2c_write_port
  import disp_i2c_pkg::*;
(
  input wire logic sys_clk_i,
  input wire logic arst_n_i,
  input wire logic scl_i,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_o,
  input wire logic addr_lsb_select_pin_i,
  input wire logic chip_reset_n_i,
  output logic ram_wr_o,
  output logic [7:0] ram_data_o,
  output logic [7:0] ram_col_o,
  output logic cmd_wr_o,
  output logic [7:0] cmd_byte_o,
  output logic busy_o,
  output display_cfg_s cfg_o
);

  port_state_s r;
  port_state_s n;

  logic scl_rise;
  logic scl_fall;
  logic start_cond;
  logic stop_cond;
  logic shifting;
  logic [7:0] byte_in;

  // ----------------------------------------
  // bus condition detection
  // ----------------------------------------
  assign scl_rise = r.scl_s2 && !r.scl_q;
  assign scl_fall = !r.scl_s2 && r.scl_q;
  assign start_cond = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
  assign stop_cond = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
  assign shifting = (r.st == ST_ADDR) || (r.st == ST_CTRL) || (r.st == ST_PAY);
  assign byte_in = {r.shift[6:0], r.sda_s2};

  always_comb begin
    n = r;
    n.scl_s1 = scl_i;
    n.scl_s2 = r.scl_s1;
    n.scl_q = r.scl_s2;
    n.sda_s1 = sda_i;
    n.sda_s2 = r.sda_s1;
    n.sda_q = r.sda_s2;
    n.sel_s1 = addr_lsb_select_pin_i;
    n.sel_s2 = r.sel_s1;
    n.rst_s1 = chip_reset_n_i;
    n.rst_s2 = r.rst_s1;
    n.ram_wr = 1'b0;
    n.cmd_wr = 1'b0;
    n.sda_out = 1'b0;
    if (!r.rst_s2) begin
      // held for as long as the pin stays low
      n.cfg = CFG_RST;
      n.shift = 8'h00;
      n.bit_cnt = 3'h0;
      n.byte_done = 1'b0;
      n.ack_en = 1'b0;
      n.in_ack = 1'b0;
      n.col = COL_RST;
      n.arg_pend = 1'b0;
      n.st = ST_IDLE;
      n.sda_oe = 1'b0;
      n.busy = 1'b0;
    end else if (start_cond) begin
      // repeated start is accepted in any state
      n.st = ST_ADDR;
      n.bit_cnt = 3'h0;
      n.byte_done = 1'b0;
      n.in_ack = 1'b0;
      n.sda_oe = 1'b0;
      n.busy = 1'b1;
    end else if (stop_cond) begin
      n.st = ST_IDLE;
      n.in_ack = 1'b0;
      n.byte_done = 1'b0;
      n.sda_oe = 1'b0;
      n.busy = 1'b0;
    end else begin
      if (scl_rise && shifting && !r.in_ack) begin
        n.shift = byte_in;
        n.bit_cnt = r.bit_cnt + 3'h1;
        if (r.bit_cnt == LAST_BIT) begin
          n.byte_done = 1'b1;
          n.ack_en = 1'b1;
          case (r.st)
            ST_ADDR: begin
              if (addr_match(byte_in[7:1], r.sel_s2) && !byte_in[0]) begin
                n.st = ST_CTRL;
              end else begin
                // read requests are not served either
                n.ack_en = 1'b0;
                n.st = ST_IGNORE;
              end
            end
            ST_CTRL: begin
              n.cont = byte_in[CTRL_CONT_BIT];
              n.dc = byte_in[CTRL_DC_BIT];
              n.st = ST_PAY;
            end
            ST_PAY: begin
              n.st = r.cont ? ST_CTRL : ST_PAY;
              if (r.dc) begin
                n.ram_wr = 1'b1;
                n.ram_data = byte_in;
                n.ram_col = r.col;
                n.col = (r.col == COL_LAST) ? COL_RST : r.col + 8'h01;
              end else begin
                n.cmd_wr = 1'b1;
                n.cmd_byte = byte_in;
                if (r.arg_pend) begin
                  n.arg_pend = 1'b0;
                  case (r.arg_op)
                    OP_CONTRAST: n.cfg.contrast = byte_in;
                    OP_START_LINE: n.cfg.start_line = byte_in;
                    OP_COL_SET: n.col = byte_in;
                    OP_PORTRAIT: n.cfg.portrait = byte_in[0];
                    default: n.arg_pend = 1'b0;
                  endcase
                end else begin
                  case (byte_in)
                    OP_DISP_OFF: n.cfg.display_on = 1'b0;
                    OP_DISP_ON: n.cfg.display_on = 1'b1;
                    OP_COL_NORMAL: n.cfg.col_remap = 1'b0;
                    OP_COL_REMAP: n.cfg.col_remap = 1'b1;
                    OP_COM_NORMAL: n.cfg.com_remap = 1'b0;
                    OP_COM_REMAP: n.cfg.com_remap = 1'b1;
                    OP_CONTRAST, OP_START_LINE, OP_COL_SET, OP_PORTRAIT: begin
                      n.arg_pend = 1'b1;
                      n.arg_op = byte_in;
                    end
                    default: begin
                      // A4h..A7h select the display mode, others are dropped
                      if (byte_in[7:2] == OP_MODE_BASE) begin
                        n.cfg.disp_mode = byte_in[1:0];
                      end
                    end
                  endcase
                end
              end
            end
            default: n.st = r.st;
          endcase
        end
      end
      if (scl_fall) begin
        if (r.in_ack) begin
          n.in_ack = 1'b0;
          n.sda_oe = 1'b0;
        end else if (r.byte_done) begin
          // drive low when ack_en is set, from this fall until the fall after the ninth pulse
          n.byte_done = 1'b0;
          n.in_ack = 1'b1;
          n.sda_oe = r.ack_en;
        end
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      r <= '0;
      r.cfg <= CFG_RST;
      r.col <= COL_RST;
      // bus lines idle high, so release shows no false edge
      r.scl_s1 <= 1'b1;
      r.scl_s2 <= 1'b1;
      r.scl_q <= 1'b1;
      r.sda_s1 <= 1'b1;
      r.sda_s2 <= 1'b1;
      r.sda_q <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign sda_o = r.sda_out;
  assign sda_oe_o = r.sda_oe;
  assign ram_wr_o = r.ram_wr;
  assign ram_data_o = r.ram_data;
  assign ram_col_o = r.ram_col;
  assign cmd_wr_o = r.cmd_wr;
  assign cmd_byte_o = r.cmd_byte;
  assign busy_o = r.busy;
  assign cfg_o = r.cfg;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!arst_n_i);

  sequence s_last_bit(link_state_e s);
    r.rst_s2 && !start_cond && !stop_cond && scl_rise && !r.in_ack &&
      (r.st == s) && (r.bit_cnt == LAST_BIT);
  endsequence

  sequence s_addr_ok;
    s_last_bit(ST_ADDR) ##0 (addr_match(byte_in[7:1], r.sel_s2) && !byte_in[0]);
  endsequence

  property p_start_addr;
    (r.rst_s2 && start_cond) |=> (r.st == ST_ADDR) && (r.bit_cnt == 3'h0) && !r.sda_oe;
  endproperty
  a_start_addr: assert property (p_start_addr) else $error("start not taken");

  property p_addr_ack;
    s_addr_ok |=> (r.st == ST_CTRL) ##[0:1000] (r.sda_oe || start_cond || stop_cond);
  endproperty
  a_addr_ack: assert property (p_addr_ack) else $error("address not acked");

  property p_rw_read_ignored;
    (s_last_bit(ST_ADDR) ##0 byte_in[0]) |=> (r.st == ST_IGNORE) && !r.ack_en;
  endproperty
  a_rw_read_ignored: assert property (p_rw_read_ignored) else $error("read accepted");

  property p_ignore_quiet;
    (r.st == ST_IGNORE) |-> !r.sda_oe && !r.ram_wr && !r.cmd_wr;
  endproperty
  a_ignore_quiet: assert property (p_ignore_quiet) else $error("ignored traffic acted on");

  property p_ack_holds;
    (r.sda_oe && !scl_fall && !start_cond && !stop_cond && r.rst_s2) |=> r.sda_oe;
  endproperty
  a_ack_holds: assert property (p_ack_holds) else $error("ack released early");

  property p_col_step;
    r.ram_wr |-> (r.col == ((r.ram_col == COL_LAST) ? COL_RST : r.ram_col + 8'h01));
  endproperty
  a_col_step: assert property (p_col_step) else $error("column not advanced");

  property p_route;
    (r.ram_wr |-> r.dc && !r.cmd_wr) and (r.cmd_wr |-> !r.dc);
  endproperty
  a_route: assert property (p_route) else $error("byte misrouted");

  property p_cont_flow;
    s_last_bit(ST_PAY) |=> (r.st == ($past(r.cont) ? ST_CTRL : ST_PAY));
  endproperty
  a_cont_flow: assert property (p_cont_flow) else $error("payload flow wrong");

  property p_stop_idle;
    (r.rst_s2 && stop_cond && !start_cond) |=> (r.st == ST_IDLE) && !r.sda_oe && !r.busy;
  endproperty
  a_stop_idle: assert property (p_stop_idle) else $error("stop not honoured");

  property p_reset_pin;
    !r.rst_s2 |=> (r.cfg == CFG_RST) && (r.col == COL_RST) && (r.shift == 8'h00) &&
      (r.bit_cnt == 3'h0);
  endproperty
  a_reset_pin: assert property (p_reset_pin) else $error("reset pin state wrong");

  property p_busy_start;
    (r.rst_s2 && start_cond) |=> r.busy;
  endproperty
  a_busy_start: assert property (p_busy_start) else $error("busy not raised");

  property p_shift_bit;
    (r.rst_s2 && !start_cond && !stop_cond && scl_rise && shifting && !r.in_ack) |=>
      (r.bit_cnt == $past(r.bit_cnt) + 3'h1) && (r.shift[0] == $past(r.sda_s2));
  endproperty
  a_shift_bit: assert property (p_shift_bit) else $error("bit not shifted");

  property p_ctrl_latch;
    s_last_bit(ST_CTRL) |=> (r.st == ST_PAY) && (r.cont == $past(byte_in[CTRL_CONT_BIT])) &&
      (r.dc == $past(byte_in[CTRL_DC_BIT]));
  endproperty
  a_ctrl_latch: assert property (p_ctrl_latch) else $error("control byte not taken");

  property p_ram_payload;
    (s_last_bit(ST_PAY) ##0 r.dc) |=> r.ram_wr && (r.ram_data == $past(byte_in)) &&
      (r.ram_col == $past(r.col));
  endproperty
  a_ram_payload: assert property (p_ram_payload) else $error("ram write missing");

  property p_cmd_payload;
    (s_last_bit(ST_PAY) ##0 !r.dc) |=> r.cmd_wr && (r.cmd_byte == $past(byte_in));
  endproperty
  a_cmd_payload: assert property (p_cmd_payload) else $error("command byte missing");

  property p_strobe_single;
    (r.ram_wr |=> !r.ram_wr) and (r.cmd_wr |=> !r.cmd_wr);
  endproperty
  a_strobe_single: assert property (p_strobe_single) else $error("strobe too long");

  property p_ack_drive;
    (r.rst_s2 && scl_fall && !r.in_ack && r.byte_done) |=>
      r.in_ack && (r.sda_oe == $past(r.ack_en));
  endproperty
  a_ack_drive: assert property (p_ack_drive) else $error("ack not driven");

  property p_ack_release;
    (r.rst_s2 && r.in_ack && scl_fall) |=> !r.sda_oe && !r.in_ack;
  endproperty
  a_ack_release: assert property (p_ack_release) else $error("ack not released");

  property p_pin_origin;
    !r.rst_s2 |=> (r.cfg.start_line == START_LINE_RST) && (r.col == COL_RST);
  endproperty
  a_pin_origin: assert property (p_pin_origin) else $error("origin not cleared");

  property p_pin_contrast;
    !r.rst_s2 |=> (r.cfg.contrast == CONTRAST_RST) && !r.sda_oe && !r.busy;
  endproperty
  a_pin_contrast: assert property (p_pin_contrast) else $error("contrast not reset");

endmodule
`default_nettype wire

/* File: verif/bus_master_model.sv */
// behavioural two-wire bus master that drives the display port
`timescale 1ns/1ps
`default_nettype none
module bus_master_model (
  input wire logic clk_i,
  input wire logic dev_sda_i,
  input wire logic dev_sda_oe_i,
  output logic scl_o,
  output logic sda_o
);
  logic drv_ff;
  // pull-up: a released line reads high
  assign sda_o = drv_ff & (dev_sda_oe_i ? dev_sda_i : 1'b1);
  initial begin
    scl_o = 1'b1;
    drv_ff = 1'b1;
  end
  // eight system clocks a phase, well above the port's minimum
  task automatic hp();
    repeat (8) @(posedge clk_i);
  endtask
  task automatic bit_out(input logic b);
    drv_ff <= b;
    hp();
    scl_o <= 1'b1;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask
  task automatic start();
    drv_ff <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    drv_ff <= 1'b0;
    hp();
    scl_o <= 1'b0;
    hp();
  endtask
  task automatic stop();
    drv_ff <= 1'b0;
    hp();
    scl_o <= 1'b1;
    hp();
    drv_ff <= 1'b1;
    hp();
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    for (int i = 7; i >= 0; i--) bit_out(b[i]);
    drv_ff <= 1'b1;
    hp();
    scl_o <= 1'b1;
    hp();
    ack = ~sda_o;
    scl_o <= 1'b0;
    hp();
  endtask
endmodule
`default_nettype wire

/* File: verif/display_i2c_write_port_tb.sv */
// self-checking bench for the display two-wire write port
`timescale 1ns/1ps
`default_nettype none
module display_i2c_write_port_tb;
  import disp_i2c_pkg::*;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic addr_sel = 1'b0;
  logic chip_rst_n = 1'b1;
  logic scl, sda, sda_out, sda_oe, ram_wr, cmd_wr, busy;
  logic [7:0] ram_data, ram_col, cmd_byte, b;
  display_cfg_s cfg, exp_cfg;
  int miscompares = 0;
  int checks = 0;
  int col_m = 0;
  logic [15:0] exp_ram[$];
  logic [7:0] exp_cmd[$];

  always #12.5 clk = ~clk;

  display_i2c_write_port display_i2c_write_port_i (.sys_clk_i(clk), .arst_n_i(arst_n),
    .scl_i(scl), .sda_i(sda), .sda_o(sda_out), .sda_oe_o(sda_oe),
    .addr_lsb_select_pin_i(addr_sel), .chip_reset_n_i(chip_rst_n), .ram_wr_o(ram_wr),
    .ram_data_o(ram_data), .ram_col_o(ram_col), .cmd_wr_o(cmd_wr), .cmd_byte_o(cmd_byte),
    .busy_o(busy), .cfg_o(cfg));
  bus_master_model bus_master_model_i (.clk_i(clk), .dev_sda_i(sda_out),
    .dev_sda_oe_i(sda_oe), .scl_o(scl), .sda_o(sda));

  // ----------------------------------------
  // checking helpers
  // ----------------------------------------
  task automatic check(input string nm, input logic [23:0] seen, input logic [23:0] exp);
    checks++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic complete_run();
    if (miscompares == 0 && checks > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic wr(input logic [7:0] v, input logic exp_ack);
    logic a;
    bus_master_model_i.send(v, a);
    check("ack", 24'(a), 24'(exp_ack));
  endtask
  task automatic pay(input logic dc, input logic [7:0] v);
    if (dc) begin
      exp_ram.push_back({col_m[7:0], v});
      col_m = (col_m == int'(COL_LAST)) ? 0 : col_m + 1;
    end else begin
      exp_cmd.push_back(v);
    end
    wr(v, 1'b1);
  endtask
  task automatic open_wr();
    bus_master_model_i.start();
    wr({6'h1E, addr_sel, 1'b0}, 1'b1);
  endtask

  // every strobe must match the next expected byte
  // sampled mid-cycle, away from the edge that launches it
  always @(negedge clk) begin
    if (ram_wr === 1'b1) begin
      check("ram_due", 24'(exp_ram.size() > 0), 24'h1);
      if (exp_ram.size() > 0) check("ram", {8'h0, ram_col, ram_data}, 24'(exp_ram.pop_front()));
    end
    if (cmd_wr === 1'b1) begin
      check("cmd_due", 24'(exp_cmd.size() > 0), 24'h1);
      if (exp_cmd.size() > 0) check("cmd", 24'(cmd_byte), 24'(exp_cmd.pop_front()));
    end
  end

  initial begin
    repeat (40000) @(posedge clk);
    miscompares++;
    complete_run();
  end

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  initial begin
    void'($urandom(32'h07baeb04));
    repeat (4) @(posedge clk);
    arst_n <= 1'b1;
    repeat (4) @(posedge clk);
    check("cfg_rst", cfg, CFG_RST);
    for (int k = 0; k < 2; k++) begin
      addr_sel <= k[0];
      repeat (4) @(posedge clk);
      bus_master_model_i.start();
      wr({6'h1E, ~addr_sel, 1'b0}, 1'b0);
      wr(8'h40, 1'b0);
      bus_master_model_i.stop();
      bus_master_model_i.start();
      wr({6'h1E, addr_sel, 1'b1}, 1'b0);
      bus_master_model_i.stop();
    end
    addr_sel <= 1'($urandom);
    open_wr();
    check("busy", 24'(busy), 24'h1);
    wr(8'h40, 1'b1);
    repeat (5) pay(1'b1, 8'($urandom));
    bus_master_model_i.stop();
    check("busy_end", 24'(busy), 24'h0);
    // payload that looks like a control byte must stay payload
    open_wr();
    wr(8'h00, 1'b1);
    pay(1'b0, OP_COL_REMAP);
    pay(1'b0, OP_COM_REMAP);
    bus_master_model_i.stop();
    b = 8'($urandom);
    open_wr();
    wr(8'h80, 1'b1);
    pay(1'b0, OP_DISP_ON);
    wr(8'hC0, 1'b1);
    pay(1'b1, 8'($urandom));
    wr(8'h80, 1'b1);
    pay(1'b0, OP_CONTRAST);
    wr(8'h80, 1'b1);
    pay(1'b0, b);
    bus_master_model_i.stop();
    exp_cfg = CFG_RST;
    exp_cfg.display_on = 1'b1;
    exp_cfg.col_remap = 1'b1;
    exp_cfg.com_remap = 1'b1;
    exp_cfg.contrast = b;
    check("cfg", cfg, exp_cfg);
    // remaining argument commands, an unknown opcode, a column wrap
    b = 8'($urandom);
    open_wr();
    wr(8'h00, 1'b1);
    pay(1'b0, OP_START_LINE);
    pay(1'b0, b);
    pay(1'b0, OP_PORTRAIT);
    pay(1'b0, 8'h01);
    pay(1'b0, 8'hA6);
    pay(1'b0, 8'hE3);
    pay(1'b0, OP_COL_SET);
    pay(1'b0, COL_LAST);
    col_m = int'(COL_LAST);
    // repeated start with no stop before it
    open_wr();
    wr(8'h40, 1'b1);
    repeat (2) pay(1'b1, 8'($urandom));
    bus_master_model_i.stop();
    exp_cfg.start_line = b;
    exp_cfg.portrait = 1'b1;
    exp_cfg.disp_mode = 2'h2;
    check("cfg_all", cfg, exp_cfg);
    // reset pin in mid-byte drops the partial byte
    open_wr();
    wr(8'h40, 1'b1);
    repeat (3) bus_master_model_i.bit_out(1'b1);
    chip_rst_n <= 1'b0;
    repeat (6) @(posedge clk);
    check("cfg_pin", cfg, CFG_RST);
    chip_rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    col_m = 0;
    open_wr();
    wr(8'h40, 1'b1);
    pay(1'b1, 8'($urandom));
    bus_master_model_i.stop();
    repeat (8) @(posedge clk);
    check("drained", 24'(exp_ram.size() + exp_cmd.size()), 24'h0);
    complete_run();
  end
endmodule
`default_nettype wire
